// *** common/icp_pkg.sv ***
`default_nettype none

package icp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_SRC    = 101;
    localparam int NUM_CHAN   = 32;
    localparam int SRC_W      = 7;
    localparam int CHAN_W     = 5;
    localparam int CTRL_W     = 4;
    localparam int ADDR_W     = 12;
    localparam int FAST_FIRST = 0;
    localparam int FAST_LAST  = 1;
    localparam int NORM_FIRST = 2;
    localparam int NORM_LAST  = 31;
    localparam int MAP_WORDS  = 26;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_FAST_INDEX = 12'h004;
    localparam logic [11:0] ADDR_NORM_INDEX = 12'h008;
    localparam logic [11:0] ADDR_DEBUG      = 12'h00C;
    localparam logic [11:0] ADDR_ENABLE     = 12'h010;
    localparam logic [11:0] ADDR_STATUS     = 12'h020;
    localparam logic [11:0] ADDR_CLEAR      = 12'h030;
    localparam logic [11:0] ADDR_MAP        = 12'h100;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int CTRL_FAST_EN_BIT = 0;
    localparam int CTRL_NORM_EN_BIT = 1;
    localparam int CTRL_DBG_EN_LSB  = 2;
    localparam int INDEX_VALID_BIT  = 31;
    localparam int INDEX_CHAN_LSB   = 8;
    localparam int INDEX_SRC_LSB    = 0;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [4:0] MAP_RESET  = 5'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [4:0] chan;
        logic [6:0] src;
    } icp_winner_type;

endpackage

`default_nettype wire

// *** hw/icp_interrupt_channel_prioritizer.sv ***
// Function
// - Up to 101 system interrupt inputs are numbered from zero.
// - A register maps each input to any one of 32 channels.
// - Channels 0 and 1 drive only the fast host interrupt.
// - Channels 2 to 31 drive the single normal host interrupt.
// - Several inputs may share one channel.
// - The lower channel number wins between channels.
// - The lower input number wins within a channel.
// - A disabled input requests nothing.
// - A disabled host output stays low.
// - Two debug inputs are asserted when driven low.
// - Inputs are synchronised before use.
`timescale 1ns/1ps
`default_nettype none

module icp_interrupt_channel_prioritizer (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // AXI4-Lite write address and data
    input  wire logic [11:0] s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    // AXI4-Lite read
    input  wire logic [11:0] s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Interrupt sources
    input  wire logic [100:0] sys_interrupt_in,
    input  wire logic [1:0]   debug_interrupt_n_in,
    // Host interrupts
    output logic             fast_host_interrupt_out,
    output logic             normal_host_interrupt_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [100:0] sync_a, sync_b, sync_c, rise;
    logic [1:0]   dbg_a, dbg_b;
    logic [3:0]   ctrl, next_ctrl;
    logic [100:0] enable, next_enable, status, next_status, clear_mask;
    logic [4:0]   chan_map [icp_pkg::NUM_SRC];
    logic [4:0]   next_chan_map [icp_pkg::NUM_SRC];
    logic [1:0]   dbg_status, next_dbg_status, dbg_clear;
    logic         aw_full, next_aw_full, w_full, next_w_full;
    logic [11:0]  aw_addr, next_aw_addr;
    logic [31:0]  w_data, next_w_data, wmask;
    logic [3:0]   w_strb, next_w_strb;
    logic         bvalid, next_bvalid, do_write, wr_ok;
    logic [1:0]   bresp, next_bresp, rresp, next_rresp, rd_resp;
    logic         rvalid, next_rvalid;
    logic [31:0]  rdata, next_rdata, rd_word;
    logic [127:0] enable_pad, status_pad;
    logic [100:0] pending;
    icp_pkg::icp_winner_type fast_win, norm_win, fast_index, norm_index;
    logic         next_fast_out, next_norm_out;

    // ------------------------------------------------------------------
    // Input synchronisers and pulse detection
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < icp_pkg::NUM_SRC; g++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    {sync_a[g], sync_b[g], sync_c[g]} <= 3'h0;
                end else begin
                    sync_a[g] <= sys_interrupt_in[g];
                    sync_b[g] <= sync_a[g];
                    sync_c[g] <= sync_b[g];
                end
            end
            assign rise[g] = sync_b[g] & ~sync_c[g];
        end
    endgenerate

    // Debug inputs are inverted so that a low pin reads as a request.
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {dbg_a, dbg_b} <= 4'h0;
        end else begin
            dbg_a <= ~debug_interrupt_n_in;
            dbg_b <= dbg_a;
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign s_axi_awready_out = ~aw_full;
    assign s_axi_wready_out  = ~w_full;
    assign s_axi_bvalid_out  = bvalid;
    assign s_axi_bresp_out   = bresp;
    assign do_write = aw_full & w_full & ~bvalid;
    assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                    {8{w_strb[1]}}, {8{w_strb[0]}}};

    always_comb begin
        wr_ok = (aw_addr[11:6] == icp_pkg::ADDR_CTRL[11:6])
             || ((aw_addr[11:8] == icp_pkg::ADDR_MAP[11:8])
                 && (int'(aw_addr[7:2]) < icp_pkg::MAP_WORDS));
        next_aw_full = aw_full;
        next_aw_addr = aw_addr;
        next_w_full  = w_full;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        if (bvalid && s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = wr_ok ? icp_pkg::RESP_OKAY : icp_pkg::RESP_SLVERR;
        end
        if (s_axi_awvalid_in && !aw_full) begin
            next_aw_full = 1'b1;
            next_aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && !w_full) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata_in;
            next_w_strb = s_axi_wstrb_in;
        end
    end

    // ------------------------------------------------------------------
    // Configuration and pending state
    // ------------------------------------------------------------------
    always_comb begin
        next_ctrl   = ctrl;
        next_enable = enable;
        clear_mask  = '0;
        dbg_clear   = 2'h0;
        for (int i = 0; i < icp_pkg::NUM_SRC; i++) begin
            next_chan_map[i] = chan_map[i];
        end
        if (do_write) begin
            if (aw_addr[11:2] == icp_pkg::ADDR_CTRL[11:2]) begin
                next_ctrl = (ctrl & ~wmask[3:0]) | (w_data[3:0] & wmask[3:0]);
            end
            if (aw_addr[11:2] == icp_pkg::ADDR_DEBUG[11:2]) begin
                dbg_clear = w_data[1:0] & wmask[1:0];
            end
            for (int i = 0; i < icp_pkg::NUM_SRC; i++) begin
                if (int'(aw_addr[3:2]) == i / 32) begin
                    if (aw_addr[11:4] == icp_pkg::ADDR_ENABLE[11:4]
                        && wmask[i % 32]) begin
                        next_enable[i] = w_data[i % 32];
                    end
                    if (aw_addr[11:4] == icp_pkg::ADDR_CLEAR[11:4]) begin
                        clear_mask[i] = w_data[i % 32] & wmask[i % 32];
                    end
                end
                if (aw_addr[11:8] == icp_pkg::ADDR_MAP[11:8]
                    && int'(aw_addr[7:2]) == i / 4 && w_strb[i % 4]) begin
                    next_chan_map[i] = w_data[8 * (i % 4) +: 5];
                end
            end
        end
        // A pulse in the same cycle as its clear keeps the bit set.
        next_status = (status & ~clear_mask) | (rise & enable);
        next_dbg_status = (dbg_status & ~dbg_clear) | dbg_b;
    end

    // ------------------------------------------------------------------
    // Prioritisation
    // ------------------------------------------------------------------
    function automatic icp_pkg::icp_winner_type pick(
        input logic [100:0] pend,
        input logic [4:0]   cmap [icp_pkg::NUM_SRC],
        input int           lo,
        input int           hi
    );
        icp_pkg::icp_winner_type best;
        best = '0;
        // Ascending source order keeps the lower number on a tie.
        for (int s = 0; s < icp_pkg::NUM_SRC; s++) begin
            if (pend[s] && int'(cmap[s]) >= lo && int'(cmap[s]) <= hi
                && (!best.valid || cmap[s] < best.chan)) begin
                best.valid = 1'b1;
                best.chan  = cmap[s];
                best.src   = 7'(s);
            end
        end
        return best;
    endfunction

    assign pending = status & enable;
    assign fast_win = pick(pending, chan_map, icp_pkg::FAST_FIRST,
                           icp_pkg::FAST_LAST);
    assign norm_win = pick(pending, chan_map, icp_pkg::NORM_FIRST,
                           icp_pkg::NORM_LAST);

    always_comb begin
        next_fast_out = ctrl[icp_pkg::CTRL_FAST_EN_BIT]
                        & (fast_win.valid
                           | |(dbg_status
                               & ctrl[icp_pkg::CTRL_DBG_EN_LSB +: 2]));
        next_norm_out = ctrl[icp_pkg::CTRL_NORM_EN_BIT] & norm_win.valid;
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign s_axi_arready_out = ~rvalid;
    assign s_axi_rvalid_out  = rvalid;
    assign s_axi_rdata_out   = rdata;
    assign s_axi_rresp_out   = rresp;
    assign enable_pad = {27'h0000000, enable};
    assign status_pad = {27'h0000000, status};

    always_comb begin
        rd_word = '0;
        rd_resp = icp_pkg::RESP_OKAY;
        if (s_axi_araddr_in[11:2] == icp_pkg::ADDR_CTRL[11:2]) begin
            rd_word[3:0] = ctrl;
        end else if (s_axi_araddr_in[11:2]
                     == icp_pkg::ADDR_FAST_INDEX[11:2]) begin
            rd_word[icp_pkg::INDEX_VALID_BIT] = fast_index.valid;
            rd_word[icp_pkg::INDEX_CHAN_LSB +: 5] = fast_index.chan;
            rd_word[icp_pkg::INDEX_SRC_LSB +: 7] = fast_index.src;
        end else if (s_axi_araddr_in[11:2]
                     == icp_pkg::ADDR_NORM_INDEX[11:2]) begin
            rd_word[icp_pkg::INDEX_VALID_BIT] = norm_index.valid;
            rd_word[icp_pkg::INDEX_CHAN_LSB +: 5] = norm_index.chan;
            rd_word[icp_pkg::INDEX_SRC_LSB +: 7] = norm_index.src;
        end else if (s_axi_araddr_in[11:2] == icp_pkg::ADDR_DEBUG[11:2]) begin
            rd_word[1:0] = dbg_status;
        end else if (s_axi_araddr_in[11:4] == icp_pkg::ADDR_ENABLE[11:4]) begin
            rd_word = enable_pad[{s_axi_araddr_in[3:2], 5'h00} +: 32];
        end else if (s_axi_araddr_in[11:4] == icp_pkg::ADDR_STATUS[11:4]) begin
            rd_word = status_pad[{s_axi_araddr_in[3:2], 5'h00} +: 32];
        end else if (s_axi_araddr_in[11:4] == icp_pkg::ADDR_CLEAR[11:4]) begin
            rd_word = '0;
        end else if (s_axi_araddr_in[11:8] == icp_pkg::ADDR_MAP[11:8]
                     && int'(s_axi_araddr_in[7:2]) < icp_pkg::MAP_WORDS) begin
            for (int i = 0; i < icp_pkg::NUM_SRC; i++) begin
                if (int'(s_axi_araddr_in[7:2]) == i / 4) begin
                    rd_word[8 * (i % 4) +: 5] = chan_map[i];
                end
            end
        end else begin
            rd_resp = icp_pkg::RESP_SLVERR;
        end
        next_rvalid = rvalid;
        next_rdata  = rdata;
        next_rresp  = rresp;
        if (rvalid && s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid_in && !rvalid) begin
            next_rvalid = 1'b1;
            next_rdata  = rd_word;
            next_rresp  = rd_resp;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            {aw_full, w_full, bvalid, rvalid} <= 4'h0;
            {aw_addr, w_data, w_strb, rdata} <= '0;
            {bresp, rresp} <= {icp_pkg::RESP_OKAY, icp_pkg::RESP_OKAY};
            ctrl <= icp_pkg::CTRL_RESET;
            {enable, status, dbg_status, fast_index, norm_index} <= '0;
            fast_host_interrupt_out   <= 1'b0;
            normal_host_interrupt_out <= 1'b0;
            for (int i = 0; i < icp_pkg::NUM_SRC; i++) begin
                chan_map[i] <= icp_pkg::MAP_RESET;
            end
        end else begin
            {aw_full, w_full, bvalid, rvalid} <= {next_aw_full, next_w_full,
                next_bvalid, next_rvalid};
            {aw_addr, w_data, w_strb, rdata} <= {next_aw_addr, next_w_data,
                next_w_strb, next_rdata};
            {bresp, rresp, ctrl} <= {next_bresp, next_rresp, next_ctrl};
            {enable, status, dbg_status} <= {next_enable, next_status,
                next_dbg_status};
            {fast_index, norm_index} <= {fast_win, norm_win};
            fast_host_interrupt_out   <= next_fast_out;
            normal_host_interrupt_out <= next_norm_out;
            for (int i = 0; i < icp_pkg::NUM_SRC; i++) begin
                chan_map[i] <= next_chan_map[i];
            end
        end
    end

endmodule

`default_nettype wire

// *** tb/icp_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module icp_chk (
    // Clock and reset
    input wire logic        clk_in,
    input wire logic        reset_in,
    // Register bus
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic        s_axi_bready_in,
    input wire logic        s_axi_arvalid_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0]  s_axi_rresp_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic        s_axi_rready_in,
    // Host interrupts
    input wire logic        fast_host_interrupt_out,
    input wire logic        normal_host_interrupt_out
);
    logic wr_seen, next_wr_seen;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    // Set once a write has completed.
    always_comb next_wr_seen = reset_in ? 1'b0 :
        (wr_seen | (s_axi_bvalid_out & s_axi_bready_in));
    always_ff @(posedge clk_in) wr_seen <= next_wr_seen;

    sequence s_wr_taken;
        s_axi_awvalid_in && s_axi_awready_out &&
        s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence s_wr_done;
        s_axi_bvalid_out && s_axi_bready_in;
    endsequence

    property p_wr_answer;
        s_wr_taken |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out;
    endproperty
    property p_ready_back;
        s_wr_done |-> s_axi_awready_out && s_axi_wready_out;
    endproperty
    property p_b_hold;
        s_axi_bvalid_out && !s_axi_bready_in |=>
            s_axi_bvalid_out && $stable(s_axi_bresp_out);
    endproperty
    property p_rd_answer;
        s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
    endproperty
    property p_r_hold;
        s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
            $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out);
    endproperty
    property p_quiet;
        !wr_seen |-> !fast_host_interrupt_out && !normal_host_interrupt_out;
    endproperty
    property p_fast_sticky;
        $fell(fast_host_interrupt_out) |->
            $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2);
    endproperty
    property p_norm_sticky;
        $fell(normal_host_interrupt_out) |->
            $past(s_axi_bvalid_out) || $past(s_axi_bvalid_out, 2);
    endproperty

    a_wr_answer: assert property (p_wr_answer)
        else $error("write answer late");
    a_ready_back: assert property (p_ready_back)
        else $error("readies low after response");
    a_b_hold: assert property (p_b_hold)
        else $error("write response not held");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read answer late");
    a_r_hold: assert property (p_r_hold)
        else $error("read data not held");
    a_quiet: assert property (p_quiet)
        else $error("host line high before setup");
    a_fast_sticky: assert property (p_fast_sticky)
        else $error("fast line fell unprompted");
    a_norm_sticky: assert property (p_norm_sticky)
        else $error("normal line fell unprompted");
endmodule

`default_nettype wire

// *** tb/icp_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module icp_host_model (
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // Host interrupt requests
    input  wire logic fast_host_interrupt_in,
    input  wire logic normal_host_interrupt_in,
    // Handler entries taken
    output logic [7:0] fast_entry_out,
    output logic [7:0] normal_entry_out
);
    logic fast_q;
    logic norm_q;

    // The core enters its handler once for each rising request level.
    always_ff @(posedge clk_in) begin
        fast_q <= reset_in ? 1'b0 : fast_host_interrupt_in;
        norm_q <= reset_in ? 1'b0 : normal_host_interrupt_in;
        if (reset_in) begin
            fast_entry_out   <= 8'h00;
            normal_entry_out <= 8'h00;
        end else begin
            if (fast_host_interrupt_in && !fast_q)
                fast_entry_out <= fast_entry_out + 8'h01;
            if (normal_host_interrupt_in && !norm_q)
                normal_entry_out <= normal_entry_out + 8'h01;
        end
    end
endmodule

`default_nettype wire

// *** tb/icp_interrupt_channel_prioritizer_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module icp_interrupt_channel_prioritizer_bench;
    logic         clk_in, reset_in;
    logic [11:0]  s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0]  s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0]   s_axi_wstrb_in;
    logic [1:0]   s_axi_bresp_out, s_axi_rresp_out, debug_interrupt_n_in;
    logic         s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
    logic         s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
    logic         s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
    logic         s_axi_rready_in, fast_host_interrupt_out;
    logic         normal_host_interrupt_out;
    logic [100:0] sys_interrupt_in;
    logic [7:0]   fast_entry, normal_entry;
    int           err_total, n_checks;

    icp_interrupt_channel_prioritizer u_icp_interrupt_channel_prioritizer (
        .clk_in(clk_in), .reset_in(reset_in),
        .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
        .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
        .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
        .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
        .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
        .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
        .s_axi_arready_out(s_axi_arready_out),
        .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
        .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
        .sys_interrupt_in(sys_interrupt_in),
        .debug_interrupt_n_in(debug_interrupt_n_in),
        .fast_host_interrupt_out(fast_host_interrupt_out),
        .normal_host_interrupt_out(normal_host_interrupt_out));
    icp_host_model u_icp_host_model (.clk_in(clk_in), .reset_in(reset_in),
        .fast_host_interrupt_in(fast_host_interrupt_out),
        .normal_host_interrupt_in(normal_host_interrupt_out),
        .fast_entry_out(fast_entry), .normal_entry_out(normal_entry));

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Response ready is held back two cycles so that stalls are exercised.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = icp_pkg::RESP_OKAY);
        int n;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        for (n = 1; n < 40; n++) begin
            @(posedge clk_in);
            if (s_axi_bvalid_out && s_axi_bready_in) break;
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            s_axi_bready_in <= (n >= 3);
        end
        s_axi_bready_in <= 1'b0;
        chk("bresp", 32'(er), 32'(s_axi_bresp_out));
    endtask
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] e,
                       input logic [1:0] er = icp_pkg::RESP_OKAY);
        int n;
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        for (n = 1; n < 40; n++) begin
            @(posedge clk_in);
            if (s_axi_rvalid_out && s_axi_rready_in) break;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            s_axi_rready_in <= (n >= 2);
        end
        s_axi_rready_in <= 1'b0;
        chk(nm, e, s_axi_rdata_out);
        chk("rresp", 32'(er), 32'(s_axi_rresp_out));
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic pulse(input logic [100:0] m);
        @(posedge clk_in);
        sys_interrupt_in <= m;
        @(posedge clk_in);
        sys_interrupt_in <= '0;
    endtask
    task automatic map_to(input int s, input logic [4:0] c);
        wr(icp_pkg::ADDR_MAP + 12'(4 * (s / 4)), 32'(c) << (8 * (s % 4)));
    endtask
    function automatic logic [31:0] idx(input logic [4:0] c,
                                        input logic [6:0] s);
        return {1'b1, 18'h0, c, 1'b0, s};
    endfunction
    function automatic logic [31:0] lines();
        return {30'h0, fast_host_interrupt_out, normal_host_interrupt_out};
    endfunction

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk("lines", 32'h0, lines());
        rdc("ctrl", icp_pkg::ADDR_CTRL, 32'h0);
        rdc("enable", icp_pkg::ADDR_ENABLE, 32'h0);
        rdc("map", icp_pkg::ADDR_MAP, 32'h0);
        rdc("fast index", icp_pkg::ADDR_FAST_INDEX, 32'h0);
        rdc("hole", 12'h200, 32'h0, icp_pkg::RESP_SLVERR);
        wr(12'h200, 32'hFFFF_FFFF, icp_pkg::RESP_SLVERR);
    endtask
    task automatic t_fast();
        map_to(3, 5'h01);
        wr(icp_pkg::ADDR_ENABLE, 32'h0000_0008);
        pulse(101'h28);
        tick(6);
        rdc("status", icp_pkg::ADDR_STATUS, 32'h0000_0008);
        rdc("fast index", icp_pkg::ADDR_FAST_INDEX, idx(1, 3));
        chk("host off", 32'h0, lines());
        wr(icp_pkg::ADDR_CTRL, 32'h1);
        tick(3);
        chk("fast on", 32'h2, lines());
        chk("fast entries", 32'h1, 32'(fast_entry));
        wr(icp_pkg::ADDR_CLEAR, 32'h0000_0008);
        tick(3);
        chk("fast clear", 32'h0, lines());
    endtask
    task automatic t_prio();
        wr(icp_pkg::ADDR_CTRL, 32'h2);
        map_to(10, 5'h02);
        map_to(70, 5'h02);
        map_to(40, 5'h05);
        map_to(100, 5'h1F);
        wr(icp_pkg::ADDR_ENABLE, 32'h0000_0400);
        wr(icp_pkg::ADDR_ENABLE + 12'h004, 32'h0000_0100);
        wr(icp_pkg::ADDR_ENABLE + 12'h008, 32'h0000_0040);
        wr(icp_pkg::ADDR_ENABLE + 12'h00C, 32'h0000_0010);
        pulse((101'h1 << 10) | (101'h1 << 40) | (101'h1 << 70)
              | (101'h1 << 100));
        tick(6);
        chk("normal on", 32'h1, lines());
        rdc("norm index", icp_pkg::ADDR_NORM_INDEX, idx(2, 10));
        wr(icp_pkg::ADDR_CLEAR, 32'h0000_0400);
        rdc("norm index", icp_pkg::ADDR_NORM_INDEX, idx(2, 70));
        wr(icp_pkg::ADDR_CLEAR + 12'h008, 32'h0000_0040);
        rdc("norm index", icp_pkg::ADDR_NORM_INDEX, idx(5, 40));
        wr(icp_pkg::ADDR_CLEAR + 12'h004, 32'h0000_0100);
        rdc("norm index", icp_pkg::ADDR_NORM_INDEX, idx(31, 100));
        chk("normal held", 32'h1, lines());
        wr(icp_pkg::ADDR_CLEAR + 12'h00C, 32'h0000_0010);
        tick(3);
        chk("normal clear", 32'h0, lines());
        chk("normal entries", 32'h1, 32'(normal_entry));
    endtask
    task automatic t_debug();
        wr(icp_pkg::ADDR_CTRL, 32'h5);
        @(posedge clk_in);
        debug_interrupt_n_in <= 2'b10;
        @(posedge clk_in);
        debug_interrupt_n_in <= 2'b11;
        tick(6);
        chk("debug fast", 32'h2, lines());
        rdc("debug", icp_pkg::ADDR_DEBUG, 32'h1);
        wr(icp_pkg::ADDR_DEBUG, 32'h1);
        tick(3);
        chk("debug clear", 32'h0, lines());
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    initial begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        conclude();
    end
    initial begin
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
        {s_axi_arvalid_in, s_axi_rready_in, sys_interrupt_in} = '0;
        s_axi_wstrb_in = 4'hF;
        debug_interrupt_n_in = 2'b11;
        err_total = 0;
        n_checks = 0;
        reset_in = 1'b1;
        repeat (4) @(posedge clk_in);
        reset_in <= 1'b0;
        t_reset();
        t_fast();
        t_prio();
        t_debug();
        conclude();
    end
endmodule

bind icp_interrupt_channel_prioritizer icp_chk u_icp_chk (
    .clk_in(clk_in), .reset_in(reset_in),
    .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .fast_host_interrupt_out(fast_host_interrupt_out),
    .normal_host_interrupt_out(normal_host_interrupt_out));

`default_nettype wire
